//--- rtl/acp_pkg.sv
package acp_pkg;

	// Register addresses on the plain port.
	localparam logic [3:0] ADDR_MAIN_CONTROL  = 4'h0;
	localparam logic [3:0] ADDR_REF_PIN_CFG   = 4'h1;
	localparam logic [3:0] ADDR_TIMING_FORMAT = 4'h2;
	localparam logic [3:0] ADDR_RESULT_HIGH   = 4'h3;
	localparam logic [3:0] ADDR_RESULT_LOW    = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STATUS    = 4'h5;
	localparam logic [3:0] ADDR_IRQ_ENABLE    = 4'h6;
	localparam logic [3:0] ADDR_IRQ_CLEAR     = 4'h7;

	// Field positions of the main control register.
	localparam int BIT_CONVERTER_ON = 0;
	localparam int BIT_GO_BUSY      = 1;
	localparam int CHS_LSB          = 2;
	localparam int CHS_MSB          = 5;

	// Field positions of the reference and pin configuration register.
	localparam int PCFG_LSB       = 0;
	localparam int PCFG_MSB       = 3;
	localparam int BIT_POS_REF    = 4;
	localparam int BIT_NEG_REF    = 5;

	// Writable bit mask shared by both control registers.
	localparam logic [7:0] CTRL_WRITE_MASK = 8'h3f;

	// Interrupt status layout.
	localparam int IRQ_DONE_BIT = 0;

	// Channel codes.
	localparam logic [3:0] CHS_LAST_IMPL   = 4'hc;
	localparam logic [3:0] CHS_SMALL_FIRST = 4'h5;
	localparam logic [3:0] CHS_SMALL_LAST  = 4'h7;

	// Pin configuration decoding.
	localparam logic [3:0] PCFG_FIRST_DIGITAL = 4'h3;
	localparam logic [3:0] PCFG_RESET_ANALOG  = 4'h0;
	localparam logic [3:0] PCFG_RESET_DIGITAL = 4'h7;

	// Converter geometry.
	localparam int NUM_INPUTS  = 13;
	localparam int RESULT_BITS = 12;

	// Conversion time: one sample step, one approximation step per bit, plus one final load step.
	localparam int STEP_TIME_NS   = 16;
	localparam int CLK_PERIOD_NS  = 4;
	localparam int STEP_CYCLES    = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ACP_IDLE,
		ACP_SAMPLE,
		ACP_APPROX
	} acp_state_t;

endpackage

//--- rtl/acp_sar_core.sv
`timescale 1ns/1ps
`default_nettype none

module acp_sar_core #(
	parameter int RES_BITS   = 12,
	parameter int STEP_COUNT = 4
) (
	// Clock and reset.
	input  wire logic                sys_clk_i,
	input  wire logic                reset_i,
	// Control.
	input  wire logic                start_i,
	input  wire logic                abort_i,
	input  wire logic [RES_BITS-1:0] sample_i,
	input  wire logic [RES_BITS-1:0] neg_ref_i,
	input  wire logic [RES_BITS-1:0] pos_ref_i,
	// Results.
	output logic                     busy_o,
	output logic                     done_o,
	output logic [RES_BITS-1:0]      result_o
);

	localparam int BW = $clog2(RES_BITS + 1);
	localparam int SW = $clog2(STEP_COUNT + 1);

	acp_pkg::acp_state_t  state_reg, state_next;
	logic [RES_BITS-1:0]  trial_reg, trial_next;
	logic [RES_BITS-1:0]  sample_reg, sample_next;
	logic [RES_BITS-1:0]  result_reg, result_next;
	logic [BW-1:0]        bit_reg, bit_next;
	logic [SW-1:0]        step_reg, step_next;
	logic                 done_reg, done_next;

	// Maps the sample into the span between the two references.
	function automatic logic [RES_BITS-1:0] scale(input logic [RES_BITS-1:0] v,
			input logic [RES_BITS-1:0] lo, input logic [RES_BITS-1:0] hi);
		logic [2*RES_BITS-1:0] num;
		logic [RES_BITS-1:0]   span;
		num  = '0;
		span = hi - lo;
		if (v <= lo)
			return '0;
		if (v >= hi || span == '0)
			return '1;
		num = (2*RES_BITS)'(v - lo) << RES_BITS;
		num = num / (2*RES_BITS)'(span);
		return num[RES_BITS-1:0];
	endfunction

	always_comb begin
		state_next  = state_reg;
		trial_next  = trial_reg;
		sample_next = sample_reg;
		result_next = result_reg;
		bit_next    = bit_reg;
		step_next   = step_reg;
		done_next   = 1'b0;
		if (abort_i) begin
			state_next = acp_pkg::ACP_IDLE;
		end else begin
			unique case (state_reg)
				acp_pkg::ACP_IDLE: begin
					if (start_i) begin
						sample_next = scale(sample_i, neg_ref_i, pos_ref_i);
						trial_next  = '0;
						bit_next    = BW'(RES_BITS);
						step_next   = '0;
						state_next  = acp_pkg::ACP_SAMPLE;
					end
				end
				acp_pkg::ACP_SAMPLE: begin
					step_next = step_reg + 1'b1;
					if (step_reg == SW'(STEP_COUNT - 1)) begin
						step_next  = '0;
						state_next = acp_pkg::ACP_APPROX;
					end
				end
				acp_pkg::ACP_APPROX: begin
					step_next = step_reg + 1'b1;
					if (step_reg == SW'(STEP_COUNT - 1)) begin
						step_next = '0;
						if (bit_reg == '0) begin
							result_next = trial_reg;
							done_next   = 1'b1;
							state_next  = acp_pkg::ACP_IDLE;
						end else begin
							if ((trial_reg | (RES_BITS'(1) << (bit_reg - 1'b1))) <= sample_reg)
								trial_next = trial_reg | (RES_BITS'(1) << (bit_reg - 1'b1));
							bit_next = bit_reg - 1'b1;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state_reg  <= acp_pkg::ACP_IDLE;
			trial_reg  <= '0;
			sample_reg <= '0;
			result_reg <= '0;
			bit_reg    <= '0;
			step_reg   <= '0;
			done_reg   <= 1'b0;
		end else begin
			state_reg  <= state_next;
			trial_reg  <= trial_next;
			sample_reg <= sample_next;
			result_reg <= result_next;
			bit_reg    <= bit_next;
			step_reg   <= step_next;
			done_reg   <= done_next;
		end
	end

	assign busy_o   = (state_reg != acp_pkg::ACP_IDLE);
	assign done_o   = done_reg;
	assign result_o = result_reg;

endmodule // acp_sar_core

`default_nettype wire

//--- rtl/acp_converter_ctrl.sv
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Bits 5..2 select channel; codes 0..12 route inputs 0..12.
// - Codes 13..15 have no input; conversion returns the floating input value.
// - Small variant treats codes 5..7 as unimplemented too.
// - Thirteen inputs on large variant, ten on small, one shared converter.
// - Each conversion yields a 12-bit unsigned result.
// - Bit 1 reads 1 during conversion, 0 when idle, while enabled; if a start lands in the core_done cycle, it reads 0 for one cycle.
// - Bit 0 powers the converter; clearing it disables the module.
// - Bits 7..6 of both control registers ignore writes, read zero.
// - Bit 5 of second register: 1 uses input two as negative reference.
// - Bit 4 of second register: 1 uses input three as positive reference.
// - Pin config 0..2 all analog; each step from 3 makes one more digital.
// - Reset loads pin config 0 or 7 per the port-B analog default strap.
// - On completion load results, clear busy bit, set done flag.
// - Reset restores all registers, turns module off, aborts conversion.
module acp_converter_ctrl #(
	parameter int          NUM_INPUTS   = acp_pkg::NUM_INPUTS,
	parameter int          RES_BITS     = acp_pkg::RESULT_BITS,
	parameter bit          SMALL_VARIANT = 1'b0,
	parameter logic [11:0] FLOAT_VALUE  = 12'h800
) (
	// Clock and reset.
	input  wire logic                 sys_clk_i,
	input  wire logic                 reset_i,
	// Register port.
	input  wire logic [3:0]           reg_addr_i,
	input  wire logic [7:0]           reg_wdata_i,
	input  wire logic                 reg_write_i,
	input  wire logic                 reg_read_i,
	output logic [7:0]                reg_rdata_o,
	// Configuration strap.
	input  wire logic                 portb_analog_default_i,
	// Analog inputs as digitised levels.
	input  wire logic [NUM_INPUTS*RES_BITS-1:0] analog_level_i,
	// Status towards the pins and system.
	output logic [NUM_INPUTS-1:0]     pin_is_analog_o,
	output logic                      converter_powered_o,
	output logic                      irq_o
);

	logic [7:0]          main_ctrl_reg, main_ctrl_next;
	logic [7:0]          ref_pin_reg, ref_pin_next;
	logic [7:0]          timing_reg, timing_next;
	logic [RES_BITS-1:0] result_reg, result_next;
	logic [7:0]          irq_status_reg, irq_status_next;
	logic [7:0]          irq_enable_reg, irq_enable_next;
	logic [7:0]          rdata_reg, rdata_next;
	logic [NUM_INPUTS-1:0] pin_analog_reg, pin_analog_next;
	logic                powered_reg, powered_next;
	logic                irq_reg, irq_next;
	logic                strap_meta_reg, strap_sync_reg;
	logic                strap_load_reg;
	logic                start_pulse;
	logic                core_busy;
	logic                core_done;
	logic [RES_BITS-1:0] core_result;
	logic [RES_BITS-1:0] sel_level;
	logic [RES_BITS-1:0] neg_level;
	logic [RES_BITS-1:0] pos_level;
	logic [3:0]          chs;
	logic [3:0]          pcfg;

	// Reports whether a channel code reaches a real input.
	function automatic logic channel_present(input logic [3:0] code);
		if (code > acp_pkg::CHS_LAST_IMPL)
			return 1'b0;
		if (SMALL_VARIANT && code >= acp_pkg::CHS_SMALL_FIRST &&
				code <= acp_pkg::CHS_SMALL_LAST)
			return 1'b0;
		return 1'b1;
	endfunction

	// Picks the level of one input from the flat bundle.
	function automatic logic [RES_BITS-1:0] input_level(input logic [3:0] code);
		return analog_level_i[code*RES_BITS +: RES_BITS];
	endfunction

	// Turns the pin configuration code into a per-input analog mask.
	function automatic logic [NUM_INPUTS-1:0] pin_mask(input logic [3:0] code);
		logic [NUM_INPUTS-1:0] m;
		int                    digital;
		m       = '1;
		digital = 0;
		if (code >= acp_pkg::PCFG_FIRST_DIGITAL)
			digital = int'(code - acp_pkg::PCFG_FIRST_DIGITAL) + 1;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			if (i >= NUM_INPUTS - digital)
				m[i] = 1'b0;
		end
		return m;
	endfunction

	assign chs  = main_ctrl_reg[acp_pkg::CHS_MSB:acp_pkg::CHS_LSB];
	assign pcfg = ref_pin_reg[acp_pkg::PCFG_MSB:acp_pkg::PCFG_LSB];

	// Input multiplexer and reference selection.
	always_comb begin
		sel_level = FLOAT_VALUE;
		if (channel_present(chs))
			sel_level = input_level(chs);
		neg_level = '0;
		if (ref_pin_reg[acp_pkg::BIT_NEG_REF])
			neg_level = input_level(4'h2);
		pos_level = '1;
		if (ref_pin_reg[acp_pkg::BIT_POS_REF])
			pos_level = input_level(4'h3);
	end

	// A start is taken only with the module on and the converter idle.
	assign start_pulse = reg_write_i && reg_addr_i == acp_pkg::ADDR_MAIN_CONTROL &&
		reg_wdata_i[acp_pkg::BIT_GO_BUSY] && reg_wdata_i[acp_pkg::BIT_CONVERTER_ON] &&
		main_ctrl_reg[acp_pkg::BIT_CONVERTER_ON] && !core_busy;

	acp_sar_core #(
		.RES_BITS   (RES_BITS),
		.STEP_COUNT (acp_pkg::STEP_CYCLES)
	) u_core (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.start_i   (start_pulse),
		.abort_i   (!main_ctrl_reg[acp_pkg::BIT_CONVERTER_ON]),
		.sample_i  (sel_level),
		.neg_ref_i (neg_level),
		.pos_ref_i (pos_level),
		.busy_o    (core_busy),
		.done_o    (core_done),
		.result_o  (core_result)
	);

	// Register file, interrupt logic and read data.
	always_comb begin
		main_ctrl_next  = main_ctrl_reg;
		ref_pin_next    = ref_pin_reg;
		timing_next     = timing_reg;
		result_next     = result_reg;
		irq_status_next = irq_status_reg;
		irq_enable_next = irq_enable_reg;
		rdata_next      = '0;
		if (reg_write_i) begin
			unique case (reg_addr_i)
				acp_pkg::ADDR_MAIN_CONTROL:
					main_ctrl_next = reg_wdata_i & acp_pkg::CTRL_WRITE_MASK;
				acp_pkg::ADDR_REF_PIN_CFG:
					ref_pin_next = reg_wdata_i & acp_pkg::CTRL_WRITE_MASK;
				acp_pkg::ADDR_TIMING_FORMAT:
					timing_next = reg_wdata_i;
				acp_pkg::ADDR_IRQ_ENABLE:
					irq_enable_next = reg_wdata_i;
				acp_pkg::ADDR_IRQ_CLEAR:
					irq_status_next = irq_status_reg & ~reg_wdata_i;
				default: ;
			endcase
		end
		// The busy bit follows the converter, never the stored write value.
		main_ctrl_next[acp_pkg::BIT_GO_BUSY] = start_pulse ||
			(core_busy && !core_done && main_ctrl_next[acp_pkg::BIT_CONVERTER_ON]);
		if (core_done) begin
			result_next = core_result;
			main_ctrl_next[acp_pkg::BIT_GO_BUSY] = 1'b0;
			irq_status_next[acp_pkg::IRQ_DONE_BIT] = 1'b1;
		end
		if (reg_read_i) begin
			unique case (reg_addr_i)
				acp_pkg::ADDR_MAIN_CONTROL:  rdata_next = main_ctrl_reg;
				acp_pkg::ADDR_REF_PIN_CFG:   rdata_next = ref_pin_reg;
				acp_pkg::ADDR_TIMING_FORMAT: rdata_next = timing_reg;
				acp_pkg::ADDR_RESULT_HIGH:   rdata_next = 8'(result_reg >> 8);
				acp_pkg::ADDR_RESULT_LOW:    rdata_next = result_reg[7:0];
				acp_pkg::ADDR_IRQ_STATUS:    rdata_next = irq_status_reg;
				acp_pkg::ADDR_IRQ_ENABLE:    rdata_next = irq_enable_reg;
				default:                     rdata_next = '0;
			endcase
		end
		pin_analog_next = pin_mask(pcfg);
		powered_next    = main_ctrl_reg[acp_pkg::BIT_CONVERTER_ON];
		irq_next        = |(irq_status_reg & irq_enable_reg);
	end

	// Strap synchroniser and one-shot load just after reset release.
	always_ff @(posedge sys_clk_i) begin
		strap_meta_reg <= portb_analog_default_i;
		strap_sync_reg <= strap_meta_reg;
		if (reset_i)
			strap_load_reg <= 1'b1;
		else
			strap_load_reg <= 1'b0;
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			main_ctrl_reg  <= '0;
			ref_pin_reg    <= '0;
			timing_reg     <= '0;
			result_reg     <= '0;
			irq_status_reg <= '0;
			irq_enable_reg <= '0;
			rdata_reg      <= '0;
			pin_analog_reg <= '0;
			powered_reg    <= 1'b0;
			irq_reg        <= 1'b0;
		end else begin
			main_ctrl_reg  <= main_ctrl_next;
			ref_pin_reg    <= ref_pin_next;
			if (strap_load_reg)
				ref_pin_reg[acp_pkg::PCFG_MSB:acp_pkg::PCFG_LSB] <= strap_sync_reg ?
					acp_pkg::PCFG_RESET_ANALOG : acp_pkg::PCFG_RESET_DIGITAL;
			timing_reg     <= timing_next;
			result_reg     <= result_next;
			irq_status_reg <= irq_status_next;
			irq_enable_reg <= irq_enable_next;
			rdata_reg      <= rdata_next;
			pin_analog_reg <= pin_analog_next;
			powered_reg    <= powered_next;
			irq_reg        <= irq_next;
		end
	end

	assign reg_rdata_o         = rdata_reg;
	assign pin_is_analog_o     = pin_analog_reg;
	assign converter_powered_o = powered_reg;
	assign irq_o               = irq_reg;

endmodule // acp_converter_ctrl

`default_nettype wire

//--- testbench/acp_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module acp_ctrl_sva #(
	parameter int NUM_INPUTS = 13
) (
	// Clock and reset.
	input wire logic                  sys_clk_i,
	input wire logic                  reset_i,
	// Register port.
	input wire logic [3:0]            reg_addr_i,
	input wire logic [7:0]            reg_wdata_i,
	input wire logic                  reg_write_i,
	input wire logic                  reg_read_i,
	input wire logic [7:0]            reg_rdata_o,
	// Strap and status.
	input wire logic                  portb_analog_default_i,
	input wire logic [NUM_INPUTS-1:0] pin_is_analog_o,
	input wire logic                  converter_powered_o,
	input wire logic                  irq_o
);
	logic on_reg;
	logic en_reg;

	// Shadows of the enable bits, taken from the register writes.
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			on_reg <= 1'b0;
			en_reg <= 1'b0;
		end else if (reg_write_i) begin
			if (reg_addr_i == 4'h0) on_reg <= reg_wdata_i[0];
			if (reg_addr_i == 4'h6) en_reg <= reg_wdata_i[0];
		end
	end

	function automatic logic [NUM_INPUTS-1:0] dec(input logic [3:0] c);
		return {NUM_INPUTS{1'b1}} >> ((c < 4'h3) ? 4'h0 : c - 4'h2);
	endfunction

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	a_pins_reset: assert property ($fell(reset_i) |-> ##3
		pin_is_analog_o == dec(portb_analog_default_i ? 4'h0 : 4'h7)) else $error("pin default wrong");
	a_pins_decode: assert property (reg_write_i && reg_addr_i == 4'h1 |-> ##2
		pin_is_analog_o == dec($past(reg_wdata_i[3:0], 2))) else $error("pin decode wrong");
	a_powered_follow: assert property (reg_write_i && reg_addr_i == 4'h0 |-> ##2
		converter_powered_o == $past(reg_wdata_i[0], 2)) else $error("power bit wrong");
	a_ctrl_high_zero: assert property (reg_read_i && reg_addr_i < 4'h2 |=>
		reg_rdata_o[7:6] == 2'b00) else $error("upper control bits set");
	a_result_width: assert property (reg_read_i && reg_addr_i == 4'h3 |=>
		reg_rdata_o[7:4] == 4'h0) else $error("result wider than twelve bits");
	a_idle_when_off: assert property (reg_read_i && reg_addr_i == 4'h0 && !on_reg |=>
		!reg_rdata_o[1]) else $error("busy while off");
	a_irq_masked: assert property (!en_reg |=> !irq_o) else $error("masked irq");
	a_clear_drops: assert property (reg_write_i && reg_addr_i == 4'h7 && reg_wdata_i[0]
		|-> ##2 !irq_o) else $error("irq not cleared");

	cover property (reg_write_i && reg_addr_i == 4'h7);
	cover property ($rose(irq_o));
	cover property ($fell(reset_i));
endmodule // acp_ctrl_sva
`default_nettype wire

//--- testbench/acp_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module acp_pins_model (
	// Level offset chosen by the bench.
	input  wire logic [7:0]   base_i,
	// One digitised level per input.
	output logic      [155:0] analog_level_o
);
	// Input k sits at k*256 plus the offset.
	always_comb begin
		for (int k = 0; k < 13; k++) begin
			analog_level_o[k*12 +: 12] = 12'(k * 256) + {4'h0, base_i};
		end
	end
endmodule // acp_pins_model
`default_nettype wire

//--- testbench/acp_converter_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module acp_converter_ctrl_test;
	logic         sys_clk_i = 1'b0;
	logic         reset_i = 1'b1;
	logic         reg_write_i = 1'b0;
	logic         reg_read_i = 1'b0;
	logic         strap = 1'b1;
	logic [3:0]   reg_addr_i = 4'h0;
	logic [7:0]   reg_wdata_i = 8'h00;
	logic [7:0]   reg_rdata_o;
	logic [7:0]   rdata_s;
	logic [7:0]   base = 8'h00;
	logic [155:0] levels;
	logic [12:0]  pins;
	logic         powered;
	logic         irq;
	int           n_errors = 0;
	int           check_count = 0;

	acp_pins_model pm (.base_i(base), .analog_level_o(levels));
	acp_converter_ctrl dut (.sys_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
		.reg_read_i, .reg_rdata_o, .portb_analog_default_i(strap), .analog_level_i(levels),
		.pin_is_analog_o(pins), .converter_powered_o(powered), .irq_o(irq));
	acp_converter_ctrl #(.SMALL_VARIANT(1'b1)) dut_small (.sys_clk_i, .reset_i, .reg_addr_i,
		.reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o(rdata_s),
		.portb_analog_default_i(strap), .analog_level_i(levels), .pin_is_analog_o(),
		.converter_powered_o(), .irq_o());

	initial forever #2 sys_clk_i = ~sys_clk_i;

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_write_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_read_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask

	task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		`CHK(d, e)
	endtask

	task automatic do_reset(input logic s);
		@(posedge sys_clk_i);
		strap <= s;
		reset_i <= 1'b1;
		repeat (6) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
	endtask

	function automatic int exp_res(int c, int r, bit s);
		int l;
		int neg;
		int pos;
		l = (c > 12 || (s && c >= 5 && c <= 7)) ? 'h800 : c * 256 + base;
		neg = r[1] ? 512 + base : 0;
		pos = r[0] ? 768 + base : 4095;
		if (l <= neg) return 0;
		l = (l - neg) * 4096 / (pos - neg);
		return (l > 4095) ? 4095 : l;
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (50000) @(posedge sys_clk_i);
		n_errors++;
		test_done();
	end

	initial begin
		logic [7:0] d;
		logic [7:0] h;
		logic [7:0] l;
		logic [7:0] hs;
		logic [7:0] ls;
		void'($urandom(15));
		do_reset(1'b1);
		`CHK(pins, 13'h1fff)
		chk_rd(4'h1, 8'h00);
		chk_rd(4'h0, 8'h00);
		do_reset(1'b0);
		`CHK(pins, 13'h00ff)
		chk_rd(4'h1, 8'h07);
		$display("reset test done");
		wr(4'h0, 8'hfe);
		chk_rd(4'h0, 8'h3c);
		wr(4'h1, 8'hff);
		chk_rd(4'h1, 8'h3f);
		chk_rd(4'h9, 8'h00);
		for (int c = 0; c < 16; c++) begin
			wr(4'(c), 8'(c) & 8'h0f);
			wr(4'h1, 8'(c));
			repeat (2) @(posedge sys_clk_i);
			#1 `CHK(pins, 13'h1fff >> ((c < 3) ? 0 : c - 2))
		end
		$display("pin config test done");
		wr(4'h6, 8'h01);
		wr(4'h7, 8'h01);
		for (int r = 0; r < 4; r++) begin
			for (int c = 0; c < 16; c++) begin
				@(posedge sys_clk_i);
				base <= 8'($urandom);
				wr(4'h1, 8'(r << 4));
				wr(4'h0, {2'b00, c[3:0], 2'b01});
				wr(4'h0, {2'b00, c[3:0], 2'b11});
				rd(4'h0, d);
				`CHK(d[1], 1'b1)
				`CHK(powered, 1'b1)
				for (int k = 0; k < 100 && d[1]; k++) rd(4'h0, d);
				`CHK(d, {2'b00, c[3:0], 2'b01})
				rd(4'h3, h);
				hs = rdata_s;
				rd(4'h4, l);
				ls = rdata_s;
				`CHK({h[3:0], l}, 12'(exp_res(c, r, 1'b0)))
				`CHK({hs[3:0], ls}, 12'(exp_res(c, r, 1'b1)))
				chk_rd(4'h5, 8'h01);
				`CHK(irq, 1'b1)
				wr(4'h7, 8'h01);
				repeat (2) @(posedge sys_clk_i);
				#1 `CHK(irq, 1'b0)
			end
		end
		$display("conversion test done");
		wr(4'h0, 8'h05);
		wr(4'h0, 8'h07);
		wr(4'h0, 8'h04);
		repeat (80) @(posedge sys_clk_i);
		chk_rd(4'h0, 8'h04);
		chk_rd(4'h5, 8'h00);
		`CHK(powered, 1'b0)
		wr(4'h0, 8'h05);
		wr(4'h0, 8'h07);
		do_reset(1'b1);
		repeat (80) @(posedge sys_clk_i);
		chk_rd(4'h0, 8'h00);
		chk_rd(4'h5, 8'h00);
		$display("abort test done");
		test_done();
	end
endmodule // acp_converter_ctrl_test
bind acp_converter_ctrl acp_ctrl_sva #(.NUM_INPUTS(NUM_INPUTS)) u_sva (.sys_clk_i, .reset_i,
	.reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
	.portb_analog_default_i, .pin_is_analog_o, .converter_powered_o, .irq_o);
`default_nettype wire
